// File: design/cmis_irq_status.sv
// Interrupt, status and fast wake mode registers of the clock manager.
// Assumes raw flags come from other clock domains and are synchronised here;
// cpu_wfi and cpu_wfe come from logic on mclk.
`timescale 1ns/100ps
module cmis_irq_status (
  input wire logic mclk,
  input wire logic rst,
  input wire cmis_pkg::cmis_raw_t raw_flags,
  input wire logic cpu_wfi,
  input wire logic cpu_wfe,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic clk_irq,
  output logic fast_restart_req,
  output logic cpu_sleep_req,
  output logic system_wait_req,
  output logic [1:0] flash_sleep_kind,
  output logic flash_sleep_force
);

  cmis_pkg::cmis_state_t q;
  cmis_pkg::cmis_state_t d;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Status word built from synchronised flags
  function automatic logic [31:0] status_word(input cmis_pkg::cmis_raw_t s, input logic ev);
    logic [31:0] w;
    w = 32'h00000000;
    w[cmis_pkg::BIT_MAIN_XTAL] = s.main_xtal_ready;
    w[cmis_pkg::BIT_PLL_A] = s.pll_a_locked;
    w[cmis_pkg::BIT_MASTER_CLK] = s.master_clk_ready;
    w[cmis_pkg::BIT_USB_PLL] = s.usb_pll_locked;
    w[cmis_pkg::BIT_SLOW_SRC] = s.slow_src_is_xtal;
    w[cmis_pkg::BIT_PROG_CLK0 +: 7] = s.prog_clk_ready;
    w[cmis_pkg::BIT_MAIN_SWITCH] = s.main_src_switch_done;
    w[cmis_pkg::BIT_FAST_RC] = s.fast_rc_ready;
    w[cmis_pkg::BIT_FAIL_EVENT] = ev;
    w[cmis_pkg::BIT_FAIL_LIVE] = s.failure_live_status;
    w[cmis_pkg::BIT_FAULT_OUT] = s.fault_output_active;
    w[cmis_pkg::BIT_SLOW_ERR] = s.slow_xtal_error;
    return w;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strobe_bits(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Address decode shared by read and write paths
  function automatic logic is_mapped(input logic [31:0] a);
    return (a == cmis_pkg::ADDR_IRQ_ENABLE_SET) || (a == cmis_pkg::ADDR_IRQ_ENABLE_CLEAR) ||
           (a == cmis_pkg::ADDR_CLOCK_STATUS) || (a == cmis_pkg::ADDR_IRQ_MASK) ||
           (a == cmis_pkg::ADDR_FAST_WAKE_MODE) || (a == cmis_pkg::ADDR_WRITE_LOCK);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // All behaviour in one combinational pass over the state copy
  always_comb begin
    logic [31:0] status;
    logic [31:0] bits;
    logic fail_rise;
    logic status_read;
    status = status_word(q.sync2, q.failure_event_flag);
    bits = 32'h00000000;
    fail_rise = q.sync2.failure_live_status & ~q.fail_prev;
    status_read = 1'b0;
    d = q;

    // Two-stage synchroniser; first stage feeds only the second
    d.sync1 = raw_flags;
    d.sync2 = q.sync1;
    d.fail_prev = q.sync2.failure_live_status;

    // Write address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (d.aw_full && d.w_full && !q.bvalid) begin
      bits = d.w_data & strobe_bits(d.w_strb);
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(d.aw_addr) ? cmis_pkg::RESP_OKAY : cmis_pkg::RESP_SLVERR;
      unique case (d.aw_addr)
        cmis_pkg::ADDR_IRQ_ENABLE_SET: begin
          d.irq_mask = q.irq_mask | (bits & cmis_pkg::IRQ_SRC_MASK);
        end
        cmis_pkg::ADDR_IRQ_ENABLE_CLEAR: begin
          d.irq_mask = q.irq_mask & ~(bits & cmis_pkg::IRQ_SRC_MASK);
        end
        cmis_pkg::ADDR_FAST_WAKE_MODE: begin
          // Lock blocks the write silently; response stays OKAY
          if (!q.write_lock_on) begin
            d.fast_wake_mode = (q.fast_wake_mode & ~strobe_bits(d.w_strb)) |
                               (bits & cmis_pkg::FW_WRITABLE);
          end
        end
        cmis_pkg::ADDR_WRITE_LOCK: begin
          // Key must arrive whole, so all four lanes are required
          if (d.w_strb == 4'hF &&
              d.w_data[cmis_pkg::WL_KEY_LSB +: 24] == cmis_pkg::WL_KEY) begin
            d.write_lock_on = d.w_data[cmis_pkg::WL_ON_BIT];
          end
        end
        default: begin
          // Status and mask are read-only; writes have no effect
          d.irq_mask = d.irq_mask;
        end
      endcase
    end
    d.awready = !d.aw_full && !d.bvalid;
    d.wready = !d.w_full && !d.bvalid;

    // Read channel: one read outstanding
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = is_mapped(s_axi_araddr) ? cmis_pkg::RESP_OKAY : cmis_pkg::RESP_SLVERR;
      d.rdata = 32'h00000000; // Write-only and unmapped read as zero
      unique case (s_axi_araddr)
        cmis_pkg::ADDR_CLOCK_STATUS: begin
          d.rdata = status;
          status_read = 1'b1;
        end
        cmis_pkg::ADDR_IRQ_MASK: begin
          d.rdata = q.irq_mask;
        end
        cmis_pkg::ADDR_FAST_WAKE_MODE: begin
          d.rdata = q.fast_wake_mode;
        end
        cmis_pkg::ADDR_WRITE_LOCK: begin
          d.rdata[cmis_pkg::WL_ON_BIT] = q.write_lock_on; // Key reads as zero
        end
        default: begin
          d.rdata = 32'h00000000;
        end
      endcase
    end

    // Sticky failure event; a new detection beats the read clear
    d.failure_event_flag = (q.failure_event_flag & ~status_read) | fail_rise;

    // Interrupt from enabled source bits only
    d.irq = |(status & q.irq_mask & cmis_pkg::IRQ_SRC_MASK);

    // Fast restart from enabled wake inputs and alarms
    d.fast_restart = |(q.sync2.wake_input & q.fast_wake_mode[cmis_pkg::FW_WAKE_LSB +: 16]) |
                     (q.sync2.timer_alarm & q.fast_wake_mode[cmis_pkg::FW_TIMER_AL]) |
                     (q.sync2.calendar_alarm & q.fast_wake_mode[cmis_pkg::FW_CAL_AL]) |
                     (q.sync2.usb_alarm & q.fast_wake_mode[cmis_pkg::FW_USB_AL]);

    // Sleep selection by the deep wait bit
    if (q.fast_wake_mode[cmis_pkg::FW_DEEP_WAIT]) begin
      d.cpu_sleep = cpu_wfi;
      d.sys_wait = cpu_wfe;
    end else begin
      d.cpu_sleep = cpu_wfi | cpu_wfe;
      d.sys_wait = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset to constants only
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
      q.irq_mask <= cmis_pkg::MASK_RST;
      q.fast_wake_mode <= cmis_pkg::FW_RST;
      q.write_lock_on <= cmis_pkg::WL_RST;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign clk_irq = q.irq;
  assign fast_restart_req = q.fast_restart;
  assign cpu_sleep_req = q.cpu_sleep;
  assign system_wait_req = q.sys_wait;
  assign flash_sleep_kind = q.fast_wake_mode[cmis_pkg::FW_FLASH_KIND_LSB +: 2];
  assign flash_sleep_force = q.fast_wake_mode[cmis_pkg::FW_FLASH_FORCE];

endmodule

// File: shared/cmis_pkg.sv
// Constants and carrier types for the clock manager interrupt and status block.
// Assumes a single 50 MHz system clock domain and an AXI4-Lite register master.
//
// Summary of operation
// - Writing one to an enable-set bit sets that mask bit; zero leaves it.
// - Writing one to an enable-clear bit clears that mask bit; zero does nothing.
// - Mask register is read-only and shows enabled sources at the same positions.
// - Sources: bits 0,1,3,6, 8 to 14, 16,17,18 and 21.
// - Status bit 0 shows main crystal oscillator stabilised.
// - Status bit 3 shows master clock ready.
// - Status bit 6 shows USB PLL locked.
// - Status bit 7 shows slow clock source: zero RC, one crystal.
// - Status bits 8 to 14 show each programmable clock output ready.
// - Status bit 16 is zero while main source switch runs, one when done.
// - Status bit 17 shows fast RC oscillator stabilised.
// - Status bit 18 is set by any failure detection, cleared by status read.
// - Status bit 19 shows the live failure detector result.
// - Status bit 20 shows the failure detector fault output active.
// - Status bit 21 shows slow crystal frequency wrong or once wrong since monitoring.
// - Fast wake mode register ignores writes while write lock is on.
// - Fast wake fields: wake enables 0-15, alarms 16-18, mode 20, flash 21-22, force 23.
// - A wake input enable of one lets that input request fast restart.
// - Mode zero: either wait instruction sleeps CPU; mode one: event wait enters wait mode.
// - Write lock bit changes only with the correct 24-bit key.
package cmis_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_IRQ_ENABLE_SET = 32'h400E0660;
  localparam logic [31:0] ADDR_IRQ_ENABLE_CLEAR = 32'h400E0664;
  localparam logic [31:0] ADDR_CLOCK_STATUS = 32'h400E0668;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h400E066C;
  localparam logic [31:0] ADDR_FAST_WAKE_MODE = 32'h400E0670;
  localparam logic [31:0] ADDR_WRITE_LOCK = 32'h400E06E4;

  // Status bit positions
  localparam int BIT_MAIN_XTAL = 0;
  localparam int BIT_PLL_A = 1;
  localparam int BIT_MASTER_CLK = 3;
  localparam int BIT_USB_PLL = 6;
  localparam int BIT_SLOW_SRC = 7;
  localparam int BIT_PROG_CLK0 = 8;
  localparam int BIT_MAIN_SWITCH = 16;
  localparam int BIT_FAST_RC = 17;
  localparam int BIT_FAIL_EVENT = 18;
  localparam int BIT_FAIL_LIVE = 19;
  localparam int BIT_FAULT_OUT = 20;
  localparam int BIT_SLOW_ERR = 21;
  localparam logic [31:0] IRQ_SRC_MASK = 32'h00277F4B;
  localparam logic [31:0] MASK_RST = 32'h00000000;

  // Fast wake mode fields
  localparam int FW_WAKE_LSB = 0;
  localparam int FW_TIMER_AL = 16;
  localparam int FW_CAL_AL = 17;
  localparam int FW_USB_AL = 18;
  localparam int FW_DEEP_WAIT = 20;
  localparam int FW_FLASH_KIND_LSB = 21;
  localparam int FW_FLASH_FORCE = 23;
  localparam logic [31:0] FW_WRITABLE = 32'h00F7FFFF;
  localparam logic [31:0] FW_RST = 32'h00000000;

  // Write lock register fields
  localparam int WL_ON_BIT = 0;
  localparam int WL_KEY_LSB = 8;
  localparam logic [23:0] WL_KEY = 24'h504D43;
  localparam logic WL_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Raw flags from the oscillator, PLL, clock and wake sources
  typedef struct packed {
    logic main_xtal_ready;
    logic pll_a_locked;
    logic master_clk_ready;
    logic usb_pll_locked;
    logic slow_src_is_xtal;
    logic [6:0] prog_clk_ready;
    logic main_src_switch_done;
    logic fast_rc_ready;
    logic failure_live_status;
    logic fault_output_active;
    logic slow_xtal_error;
    logic [15:0] wake_input;
    logic timer_alarm;
    logic calendar_alarm;
    logic usb_alarm;
  } cmis_raw_t;

  // Whole state of the block
  typedef struct packed {
    cmis_raw_t sync1;
    cmis_raw_t sync2;
    logic fail_prev;
    logic failure_event_flag;
    logic [31:0] irq_mask;
    logic [31:0] fast_wake_mode;
    logic write_lock_on;
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic fast_restart;
    logic cpu_sleep;
    logic sys_wait;
  } cmis_state_t;

endpackage

// File: test/cmis_irq_status_props.sv
// Port-level checks of the clock manager interrupt and status block.
// Assumes the single mclk domain and synchronous active-high rst; bound below.
`timescale 1ns/100ps
module cmis_props (
  input wire logic mclk,
  input wire logic rst,
  input wire cmis_pkg::cmis_raw_t raw_flags,
  input wire logic cpu_wfi,
  input wire logic cpu_wfe,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic clk_irq,
  input wire logic fast_restart_req,
  input wire logic cpu_sleep_req,
  input wire logic system_wait_req,
  input wire logic [1:0] flash_sleep_kind,
  input wire logic flash_sleep_force
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Reset and bus timing
  a_reset_quiet: assert property (
    $fell(rst) |-> !clk_irq && !s_axi_bvalid && !fast_restart_req)
    else $error("outputs active after reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer missing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_error_zero: assert property (
    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  ////////////////////////////////////////////////////////////////////////
  // Sleep, wake and flash mode outputs
  a_wfi_sleeps: assert property (
    cpu_wfi |=> cpu_sleep_req)
    else $error("wfi did not sleep cpu");
  a_idle_awake: assert property (
    !cpu_wfi && !cpu_wfe |=> !cpu_sleep_req && !system_wait_req)
    else $error("sleep without wait request");
  a_wait_cause: assert property (
    system_wait_req |-> $past(cpu_wfe))
    else $error("system wait without event wait");
  a_wake_quiet: assert property (
    (raw_flags.wake_input == 16'h0 && !raw_flags.timer_alarm &&
    !raw_flags.calendar_alarm && !raw_flags.usb_alarm) [*4] |=> !fast_restart_req)
    else $error("restart without wake source");
  a_flash_by_write: assert property (
    $changed({flash_sleep_force, flash_sleep_kind}) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("flash mode changed without write");
endmodule
bind cmis_irq_status cmis_props u_props (.mclk, .rst, .raw_flags, .cpu_wfi, .cpu_wfe,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .clk_irq, .fast_restart_req,
  .cpu_sleep_req, .system_wait_req, .flash_sleep_kind, .flash_sleep_force);

// File: test/testbench.sv
// Self-checking bench for the clock manager interrupt and status block.
// Assumes cmis_pkg is compiled first; the bench acts as the AXI4-Lite master.
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  cmis_pkg::cmis_raw_t raw_flags = '0;
  logic cpu_wfi = 1'b0, cpu_wfe = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d, e;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clk_irq;
  logic fast_restart_req, cpu_sleep_req, system_wait_req, flash_sleep_force;
  logic [1:0] s_axi_bresp, s_axi_rresp, flash_sleep_kind, resp;
  int num_errors = 0, tests_run = 0;
  cmis_irq_status uut (.mclk, .rst, .raw_flags, .cpu_wfi, .cpu_wfe, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clk_irq, .fast_restart_req,
    .cpu_sleep_req, .system_wait_req, .flash_sleep_kind, .flash_sleep_force);
  // 50 MHz system clock
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  // Compare, bus and verdict tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Ready is sampled before the edge's updates land, so no race with the slave
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 99;
      end
    end
    chk("write answered", 32'h1, 32'(n == 99));
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 99;
      end
    end
    chk("read answered", 32'h1, 32'(n == 99));
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Raw flag set from a status word, placed independently of the design
  function automatic cmis_pkg::cmis_raw_t mk(input logic [31:0] v);
    cmis_pkg::cmis_raw_t f;
    f = '0;
    f.main_xtal_ready = v[0];
    f.pll_a_locked = v[1];
    f.master_clk_ready = v[3];
    f.usb_pll_locked = v[6];
    f.slow_src_is_xtal = v[7];
    f.prog_clk_ready = v[14:8];
    f.main_src_switch_done = v[16];
    f.fast_rc_ready = v[17];
    f.failure_live_status = v[19];
    f.fault_output_active = v[20];
    f.slow_xtal_error = v[21];
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    cyc(5000);
    num_errors++;
    end_sim();
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    rd(cmis_pkg::ADDR_IRQ_MASK, d);
    chk("mask after reset", 32'h0, d);
    // Walk one status flag at a time; a live failure rise also sets the event
    for (int b = 0; b < 24; b++) begin
      raw_flags <= mk(32'h1 << b);
      cyc(5);
      rd(cmis_pkg::ADDR_CLOCK_STATUS, d);
      e = ((32'h1 << b) & 32'h003B7FCB) | (b == 19 ? 32'h00040000 : 32'h0);
      chk("status 0-7", e & 32'hFF, d & 32'hFF);
      chk("status 8-15", e & 32'hFF00, d & 32'hFF00);
      chk("status 16-19", e & 32'h000F0000, d & 32'h000F0000);
      chk("status 20-31", e & 32'hFFF00000, d & 32'hFFF00000);
      if (b == 19) begin
        rd(cmis_pkg::ADDR_CLOCK_STATUS, d);
        chk("event cleared by read", 32'h00080000, d);
      end
    end
    wr(cmis_pkg::ADDR_IRQ_ENABLE_SET, 32'hFFFFFFFF);
    rd(cmis_pkg::ADDR_IRQ_MASK, d);
    chk("mask all set", cmis_pkg::IRQ_SRC_MASK, d);
    wr(cmis_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h00000001);
    wr(cmis_pkg::ADDR_IRQ_ENABLE_SET, 32'h0);
    wr(cmis_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h0);
    wr(cmis_pkg::ADDR_IRQ_MASK, 32'hFFFFFFFF);
    wr(cmis_pkg::ADDR_CLOCK_STATUS, 32'hFFFFFFFF);
    rd(cmis_pkg::ADDR_IRQ_MASK, d);
    chk("mask one cleared", cmis_pkg::IRQ_SRC_MASK & 32'hFFFFFFFE, d);
    rd(cmis_pkg::ADDR_IRQ_ENABLE_SET, d);
    chk("set register reads zero", 32'h0, d);
    raw_flags <= mk(32'h00000001);
    cyc(5);
    chk("masked source quiet", 32'h0, 32'(clk_irq));
    wr(cmis_pkg::ADDR_IRQ_ENABLE_SET, 32'h00000001);
    cyc(2);
    chk("enabled source raises", 32'h1, 32'(clk_irq));
    wr(cmis_pkg::ADDR_IRQ_ENABLE_CLEAR, 32'h00000001);
    cyc(2);
    chk("disabled source drops", 32'h0, 32'(clk_irq));
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'hFFFFFFFF);
    rd(cmis_pkg::ADDR_FAST_WAKE_MODE, d);
    chk("fast wake fields", cmis_pkg::FW_WRITABLE, d);
    chk("flash mode outputs", 32'h7, 32'({flash_sleep_force, flash_sleep_kind}));
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'h00000001);
    raw_flags.wake_input <= 16'h0002;
    cyc(5);
    chk("disabled wake input", 32'h0, 32'(fast_restart_req));
    raw_flags.wake_input <= 16'h0001;
    cyc(5);
    chk("enabled wake input", 32'h1, 32'(fast_restart_req));
    cpu_wfe <= 1'b1;
    cyc(2);
    chk("event wait sleeps cpu", 32'h2, 32'({cpu_sleep_req, system_wait_req}));
    cpu_wfe <= 1'b0;
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'h00100000);
    cpu_wfe <= 1'b1;
    cyc(2);
    chk("event wait enters wait", 32'h1, 32'({cpu_sleep_req, system_wait_req}));
    cpu_wfe <= 1'b0;
    cpu_wfi <= 1'b1;
    cyc(2);
    chk("irq wait sleeps cpu", 32'h2, 32'({cpu_sleep_req, system_wait_req}));
    cpu_wfi <= 1'b0;
    // Wrong key leaves the lock off, so the next write still lands
    wr(cmis_pkg::ADDR_WRITE_LOCK, 32'h12345601);
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'h0);
    rd(cmis_pkg::ADDR_FAST_WAKE_MODE, d);
    chk("wrong key ignored", 32'h0, d);
    wr(cmis_pkg::ADDR_WRITE_LOCK, {cmis_pkg::WL_KEY, 8'h01});
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'h00000005);
    chk("locked write response", 32'(cmis_pkg::RESP_OKAY), 32'(resp));
    rd(cmis_pkg::ADDR_FAST_WAKE_MODE, d);
    chk("locked write ignored", 32'h0, d);
    wr(cmis_pkg::ADDR_WRITE_LOCK, {cmis_pkg::WL_KEY, 8'h00});
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'h00000005);
    rd(cmis_pkg::ADDR_FAST_WAKE_MODE, d);
    chk("unlocked write lands", 32'h00000005, d);
    rd(32'h400E0700, d);
    chk("unmapped response", 32'(cmis_pkg::RESP_SLVERR), 32'(resp));
    chk("unmapped data", 32'h0, d);
    wr(32'h400E0700, 32'hFFFFFFFF);
    chk("unmapped write response", 32'(cmis_pkg::RESP_SLVERR), 32'(resp));
    // Partial strobes touch only the offered byte lanes
    s_axi_wstrb <= 4'h1;
    wr(cmis_pkg::ADDR_FAST_WAKE_MODE, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'hF;
    rd(cmis_pkg::ADDR_FAST_WAKE_MODE, d);
    chk("byte lane write", 32'h000000FF, d);
    // Mid-run reset must drop every mask bit again
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd(cmis_pkg::ADDR_IRQ_MASK, d);
    chk("mask after second reset", 32'h0, d);
    end_sim();
  end
endmodule
